// ==== rtl/csic_pkg.sv ====
package csic_pkg;
    localparam int CLK_HZ = 40000000;
    // long START hold that enters configuration mode
    localparam int HOLD_MS = 5000;
    localparam longint HOLD_CYC_L = (longint'(CLK_HZ) * HOLD_MS) / 1000 + 1;
    localparam int HOLD_CYC = int'(HOLD_CYC_L);
    // configuration blink half period
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = int'((longint'(CLK_HZ) * BLINK_MS) / 1000);
    // pairing scan timeout
    localparam int PAIR_MS = 2000;
    localparam int PAIR_CYC = int'((longint'(CLK_HZ) * PAIR_MS) / 1000);
    localparam int SYNC_STAGES = 2;
    // dipswitch field layout: bits 1..2 battery, bit 3 override, 4..8 channel
    localparam int DIP_W = 8;
    localparam int DIP_BATT_LSB = 0;
    localparam int DIP_OVR_BIT = 2;
    localparam int DIP_CHAN_LSB = 3;
    localparam int CHAN_W = 5;
    localparam int ACC_W = 20;
    localparam int CNT_W = 32;
    localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
    localparam logic [ACC_W-1:0] ACC_RST = 20'h00000;
    localparam logic [DIP_W-1:0] DIP_RST = 8'h00;
    // register port map
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_STO_CHAN = 4'h1;
    localparam logic [3:0] REG_STO_ACC = 4'h2;
    localparam logic [3:0] REG_OPER = 4'h3;
    localparam logic [3:0] REG_FW_VER = 4'h4;
    // firmware version 6.2 encoded major.minor
    localparam logic [15:0] FW_VER = 16'h0602;
    typedef enum logic [4:0] {
        ST_BOOT = 5'b00001,
        ST_RUN  = 5'b00010,
        ST_CFG  = 5'b00100,
        ST_PAIR = 5'b01000,
        ST_DOWN = 5'b10000
    } csic_state_t;
endpackage : csic_pkg

// ==== rtl/csic_ctrl.sv ====
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module csic_ctrl
    import csic_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC,
    parameter int PAIR_CYCLES = PAIR_CYC,
    parameter bit HAS_DISPLAY = 1'b0,
    parameter bit TWO_LEDS = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [DIP_W-1:0] dip_pins,
    input wire logic start_pin,
    input wire logic off_pin,
    input wire logic pair_done,
    input wire logic pair_ok,
    input wire logic [CHAN_W-1:0] pair_chan,
    input wire logic [ACC_W-1:0] pair_acc,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic infrared_receiver_pairing,
    output logic adapter_ready,
    output logic [CHAN_W-1:0] oper_chan,
    output logic [ACC_W-1:0] oper_acc,
    output logic [1:0] batt_type,
    output logic led_status,
    output logic led_batt,
    output logic shutdown
);
    logic [DIP_W-1:0] dip_s1, dip_s2;
    logic [1:0] btn_s1, btn_s2;
    logic start_s, off_s, start_d;
    csic_state_t state, next_state;
    logic [CNT_W-1:0] hold_cnt, blink_cnt, pair_cnt;
    logic [1:0] boot_cnt;
    // stored settings live in memory that outlives power-off, so no reset
    logic [CHAN_W-1:0] sto_chan = CHAN_RST;
    logic [ACC_W-1:0] sto_acc = ACC_RST;
    logic entry_guard;
    logic blink_ph;
    logic start_rel, hold_hit, pair_timeout, in_cfg;

    function automatic logic [CHAN_W-1:0] chan_field(
        input logic [DIP_W-1:0] d
    );
        chan_field = d[DIP_CHAN_LSB +: CHAN_W];
    endfunction : chan_field

    // pins come from outside, so two stages before any use
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dip_s1 <= DIP_RST;
            dip_s2 <= DIP_RST;
            btn_s1 <= 2'h0;
            btn_s2 <= 2'h0;
        end else if (clk_en) begin
            dip_s1 <= dip_pins;
            dip_s2 <= dip_s1;
            btn_s1 <= {off_pin, start_pin};
            btn_s2 <= btn_s1;
        end
    end
    assign start_s = btn_s2[0];
    assign off_s = btn_s2[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_d <= 1'b0;
        end else if (clk_en) begin
            start_d <= start_s;
        end
    end
    assign start_rel = start_d && !start_s;
    assign in_cfg = (state == ST_CFG) || (state == ST_PAIR);

    // START hold timer; counts only in run state so a hold in config is a press
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_cnt <= '0;
        end else if (clk_en) begin
            if (state == ST_RUN && start_s) begin
                if (!hold_hit) begin
                    hold_cnt <= hold_cnt + 1'b1;
                end
            end else begin
                hold_cnt <= '0;
            end
        end
    end
    assign hold_hit = hold_cnt >= CNT_W'(HOLD_CYCLES);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pair_cnt <= '0;
        end else if (clk_en) begin
            if (state == ST_PAIR) begin
                pair_cnt <= pair_cnt + 1'b1;
            end else begin
                pair_cnt <= '0;
            end
        end
    end
    assign pair_timeout = pair_cnt >= CNT_W'(PAIR_CYCLES - 1);

    always_comb begin
        next_state = state;
        case (state)
            ST_BOOT: begin
                if (boot_cnt == 2'(SYNC_STAGES)) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (off_s) begin
                    next_state = ST_DOWN;
                end else if (hold_hit) begin
                    next_state = ST_CFG;
                end
            end
            ST_CFG: begin
                if (off_s) begin
                    next_state = ST_DOWN;
                end else if (start_rel && !entry_guard) begin
                    next_state = ST_PAIR;
                end
            end
            ST_PAIR: begin
                if (off_s) begin
                    next_state = ST_DOWN;
                end else if (pair_done && pair_ok) begin
                    next_state = ST_DOWN;
                end else if (pair_done || pair_timeout) begin
                    next_state = ST_CFG;
                end
            end
            ST_DOWN: begin
                next_state = ST_DOWN;
            end
            default: begin
                next_state = ST_BOOT;
            end
        endcase
    end

    // the release that ends the entry hold must not start a pairing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            entry_guard <= 1'b0;
        end else if (clk_en) begin
            if (state == ST_RUN && next_state == ST_CFG && start_s) begin
                entry_guard <= 1'b1;
            end else if (start_rel) begin
                entry_guard <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_BOOT;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // boot lasts until the synchroniser holds real switch levels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boot_cnt <= 2'h0;
        end else if (clk_en && state == ST_BOOT) begin
            boot_cnt <= boot_cnt + 2'h1;
        end
    end

    // stored configuration; pairing wins over an adapter write
    always_ff @(posedge clk) begin
        if (rst_n && clk_en) begin
            if (state == ST_PAIR && pair_done && pair_ok) begin
                sto_chan <= pair_chan;
                sto_acc <= pair_acc;
            end else if (reg_wr && adapter_ready) begin
                if (reg_addr == REG_STO_CHAN) begin
                    sto_chan <= reg_wdata[CHAN_W-1:0];
                end else if (reg_addr == REG_STO_ACC) begin
                    sto_acc <= reg_wdata[ACC_W-1:0];
                end
            end
        end
    end

    // operating values frozen at boot so later stores wait for power-up
    // early boot cycles see reset levels; the last boot cycle wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oper_chan <= CHAN_RST;
            oper_acc <= ACC_RST;
            batt_type <= 2'h0;
        end else if (clk_en && state == ST_BOOT) begin
            batt_type <= dip_s2[DIP_BATT_LSB +: 2];
            oper_acc <= sto_acc;
            if (HAS_DISPLAY || dip_s2[DIP_OVR_BIT]) begin
                oper_chan <= sto_chan;
            end else begin
                oper_chan <= chan_field(dip_s2);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blink_cnt <= '0;
            blink_ph <= 1'b0;
        end else if (clk_en) begin
            if (!in_cfg) begin
                blink_cnt <= '0;
                blink_ph <= 1'b0;
            end else if (blink_cnt >= CNT_W'(BLINK_CYCLES - 1)) begin
                blink_cnt <= '0;
                blink_ph <= !blink_ph;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            led_status <= 1'b0;
            led_batt <= 1'b0;
            shutdown <= 1'b0;
            infrared_receiver_pairing <= 1'b0;
            adapter_ready <= 1'b0;
        end else if (clk_en) begin
            led_status <= in_cfg ? blink_ph : (state == ST_RUN);
            led_batt <= (in_cfg && TWO_LEDS) ? !blink_ph : 1'b0;
            shutdown <= next_state == ST_DOWN;
            infrared_receiver_pairing <= next_state == ST_PAIR;
            adapter_ready <= next_state == ST_CFG;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            if (!reg_rd) begin
                reg_rdata <= 32'h00000000;
            end else if (reg_addr == REG_STATUS) begin
                reg_rdata <= {27'h0, state};
            end else if (reg_addr == REG_STO_CHAN) begin
                reg_rdata <= {27'h0, sto_chan};
            end else if (reg_addr == REG_STO_ACC) begin
                reg_rdata <= {12'h0, sto_acc};
            end else if (reg_addr == REG_OPER) begin
                reg_rdata <= {5'h0, batt_type, oper_acc, oper_chan};
            end else if (reg_addr == REG_FW_VER) begin
                reg_rdata <= {16'h0, FW_VER};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end

    chk_pair_stores: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_PAIR && pair_done && pair_ok && !off_s
        |=> sto_chan == $past(pair_chan) && state == ST_DOWN)
        else $error("pairing result not stored");
    chk_fail_stays: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_PAIR && pair_done && !pair_ok && !off_s
        |=> state == ST_CFG)
        else $error("failed pairing left config mode");
    chk_off_cancel: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && in_cfg && off_s |=> state == ST_DOWN)
        else $error("off did not cancel config mode");
    chk_leds_alt: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && in_cfg && TWO_LEDS ##1 clk_en && in_cfg
        |-> led_status != led_batt)
        else $error("leds not alternating");
    chk_oper_frozen: assert property (@(posedge clk)
        disable iff (!rst_n)
        state != ST_BOOT && $past(state) != ST_BOOT
        |-> $stable(oper_chan) && $stable(oper_acc))
        else $error("operating channel changed after boot");
    chk_hold_entry: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_RUN && !hold_hit |=> state != ST_CFG)
        else $error("config entered before hold time");
    chk_dip_chan: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_BOOT && !HAS_DISPLAY && !dip_s2[DIP_OVR_BIT]
        |=> oper_chan == chan_field($past(dip_s2)))
        else $error("switch channel not used");
    chk_shut_down: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_DOWN |=> shutdown)
        else $error("no shutdown after pairing");
    chk_ready_cfg: assert property (@(posedge clk)
        disable iff (!rst_n)
        adapter_ready |-> state == ST_CFG)
        else $error("adapter ready outside config mode");
    chk_ovr_stored: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_BOOT && (HAS_DISPLAY || dip_s2[DIP_OVR_BIT])
        |=> oper_chan == $past(sto_chan))
        else $error("stored channel not used");
    chk_batt_boot: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_BOOT
        |=> batt_type == $past(dip_s2[DIP_BATT_LSB +: 2]))
        else $error("battery type not taken from switches");
    chk_pair_start: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && state == ST_CFG && start_rel && !entry_guard && !off_s
        |=> infrared_receiver_pairing)
        else $error("short press did not start pairing");
    chk_blink_step: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && in_cfg && blink_cnt == CNT_W'(BLINK_CYCLES - 1)
        ##1 clk_en && in_cfg
        |=> led_status != $past(led_status))
        else $error("status led not blinking in config mode");
endmodule : csic_ctrl

// ==== tb/csic_pair_model.sv ====
`timescale 1ns/10ps
module csic_pair_model
    import csic_pkg::*;
(
    input wire logic clk,
    input wire logic attempt,
    input wire logic [1:0] mode,
    input wire logic slow,
    input wire logic [CHAN_W-1:0] rx_chan,
    input wire logic [ACC_W-1:0] rx_acc,
    output logic pair_done,
    output logic pair_ok,
    output logic [CHAN_W-1:0] pair_chan,
    output logic [ACC_W-1:0] pair_acc
);
    // mode 0 links, 1 refuses, 2 out of range so the scan times out
    logic [5:0] cnt = 6'h00;
    initial begin
        pair_done = 1'b0;
        pair_ok = 1'b0;
        pair_chan = 5'h00;
        pair_acc = 20'h00000;
    end
    always @(posedge clk) begin
        pair_done <= 1'b0;
        pair_ok <= 1'b0;
        // values are junk outside the done pulse
        pair_chan <= ~pair_chan;
        pair_acc <= ~pair_acc;
        if (!attempt)
            cnt <= 6'h00;
        else if (cnt != 6'h3F)
            cnt <= cnt + 6'h01;
        if (attempt && cnt == (slow ? 6'h14 : 6'h03) && mode != 2'h2) begin
            pair_done <= 1'b1;
            pair_ok <= (mode == 2'h0);
            pair_chan <= rx_chan;
            pair_acc <= rx_acc;
        end
    end
endmodule : csic_pair_model

// ==== tb/test_channel_source_ir_config_ctrl.sv ====
`timescale 1ns/10ps
module test_channel_source_ir_config_ctrl;
    import csic_pkg::*;
    localparam int H = 20;
    typedef struct packed {
        logic [DIP_W-1:0] dip;
        logic [CHAN_W-1:0] chan;
        logic [1:0] batt;
    } csic_row_t;
    csic_row_t rows [4] = '{'{8'h00, 5'h00, 2'h0}, '{8'hF9, 5'h1F, 2'h1},
        '{8'h52, 5'h0A, 2'h2}, '{8'hAB, 5'h15, 2'h3}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start_pin = 1'b0;
    logic off_pin = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [DIP_W-1:0] dip_pins = 8'h00;
    logic [1:0] pm_mode = 2'h0;
    logic pm_slow = 1'b0;
    logic pair_done, pair_ok, infrared_receiver_pairing, adapter_ready;
    logic led_status, led_batt, shutdown;
    logic [CHAN_W-1:0] pair_chan, oper_chan;
    logic [ACC_W-1:0] pair_acc, oper_acc;
    logic [1:0] batt_type, d_batt;
    logic [CHAN_W-1:0] d_chan;
    logic d_led, d_led_b;
    logic clk_en = 1'b1;
    logic [31:0] reg_rdata, a, b;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    csic_ctrl #(.HOLD_CYCLES(H), .BLINK_CYCLES(4), .PAIR_CYCLES(50))
    csic_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .dip_pins(dip_pins),
        .start_pin(start_pin), .off_pin(off_pin), .pair_done(pair_done),
        .pair_ok(pair_ok), .pair_chan(pair_chan), .pair_acc(pair_acc),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .infrared_receiver_pairing(infrared_receiver_pairing),
        .adapter_ready(adapter_ready), .oper_chan(oper_chan),
        .oper_acc(oper_acc), .batt_type(batt_type), .led_status(led_status),
        .led_batt(led_batt), .shutdown(shutdown));

    // display variant with one indicator, in lockstep with the one above
    csic_ctrl #(.HOLD_CYCLES(H), .BLINK_CYCLES(4), .PAIR_CYCLES(50),
        .HAS_DISPLAY(1'b1), .TWO_LEDS(1'b0))
    csic_ctrl_disp_inst (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .dip_pins(dip_pins),
        .start_pin(start_pin), .off_pin(off_pin), .pair_done(pair_done),
        .pair_ok(pair_ok), .pair_chan(pair_chan), .pair_acc(pair_acc),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(), .infrared_receiver_pairing(),
        .adapter_ready(), .oper_chan(d_chan), .oper_acc(),
        .batt_type(d_batt), .led_status(d_led), .led_batt(d_led_b),
        .shutdown());

    csic_pair_model csic_pair_model_inst (
        .clk(clk), .attempt(infrared_receiver_pairing), .mode(pm_mode),
        .slow(pm_slow), .rx_chan(5'h13), .rx_acc(20'hABCDE),
        .pair_done(pair_done), .pair_ok(pair_ok), .pair_chan(pair_chan),
        .pair_acc(pair_acc));

    task automatic conclude;
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] ad, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic waitv(ref logic s, input logic v);
        for (int i = 0; i < 200 && s !== v; i++)
            @(posedge clk);
        #1;
    endtask : waitv

    task automatic boot(input logic [7:0] d);
        @(posedge clk);
        dip_pins <= d;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask : boot

    task automatic press(input int n);
        @(posedge clk);
        start_pin <= 1'b1;
        repeat (n) @(posedge clk);
        start_pin <= 1'b0;
    endtask : press

    task automatic enter_cfg;
        @(posedge clk);
        start_pin <= 1'b1;
        repeat (H) @(posedge clk);
        #1 check("early_cfg", adapter_ready, 1'b0);
        repeat (8) @(posedge clk);
        start_pin <= 1'b0;
        waitv(adapter_ready, 1'b1);
        check("cfg_mode", adapter_ready, 1'b1);
    endtask : enter_cfg

    task automatic blink;
        int tog;
        int tog1;
        logic l0;
        logic l1;
        tog = 0;
        tog1 = 0;
        l0 = led_status;
        l1 = d_led;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1 check("led_alt", led_status ^ led_batt, 1'b1);
            check("led_one", d_led_b, 1'b0);
            if (led_status !== l0)
                tog++;
            if (d_led !== l1)
                tog1++;
            l0 = led_status;
            l1 = d_led;
        end
        check("led_blink", tog > 1, 1'b1);
        check("led_single", tog1 > 1, 1'b1);
    endtask : blink

    always @(posedge clk) begin
        cycles++;
        // far above the few hundred cycles the sequence needs
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        for (int r = 0; r < 4; r++) begin
            boot(rows[r].dip);
            check("batt", batt_type, rows[r].batt);
            check("chan", oper_chan, rows[r].chan);
            check("d_batt", d_batt, rows[r].batt);
            check("d_chan", d_chan, CHAN_RST);
            @(posedge clk);
            dip_pins <= ~rows[r].dip;
            repeat (8) @(posedge clk);
            #1 check("chan_held", oper_chan, rows[r].chan);
            check("batt_held", batt_type, rows[r].batt);
        end
        boot(8'h48);
        rd(REG_STO_CHAN, a);
        wr(REG_STO_CHAN, 32'h1F);
        rd(REG_STO_CHAN, b);
        check("locked_wr", b, a);
        enter_cfg();
        blink();
        // a low clock enable freezes the blink pattern in place
        @(posedge clk);
        clk_en <= 1'b0;
        #1 a = {30'h0, led_status, led_batt};
        repeat (9) @(posedge clk);
        #1 check("frozen", {led_status, led_batt}, a);
        @(posedge clk);
        clk_en <= 1'b1;
        wr(REG_STO_CHAN, 32'h0C);
        wr(REG_STO_ACC, 32'hFFFFF);
        rd(REG_STO_CHAN, a);
        check("sto_chan", a, 32'h0C);
        rd(REG_STO_ACC, a);
        check("sto_acc", a, 32'hFFFFF);
        rd(REG_FW_VER, a);
        check("fw_ver", a, {16'h0000, FW_VER});
        rd(4'hF, a);
        check("unmapped", a, 32'h0);
        for (int m = 2; m > 0; m--) begin
            pm_mode <= 2'(m);
            pm_slow <= 1'b1;
            press(3);
            waitv(infrared_receiver_pairing, 1'b1);
            check("pair_go", infrared_receiver_pairing, 1'b1);
            waitv(infrared_receiver_pairing, 1'b0);
            check("stay_cfg", adapter_ready, 1'b1);
        end
        blink();
        rd(REG_STO_CHAN, a);
        check("fail_kept", a, 32'h0C);
        pm_mode <= 2'h0;
        pm_slow <= 1'b0;
        press(3);
        waitv(shutdown, 1'b1);
        check("shutdown", shutdown, 1'b1);
        check("leds_off", {led_status, led_batt}, 2'b00);
        check("oper_kept", oper_chan, 5'h09);
        rd(REG_STO_CHAN, a);
        check("pair_chan", a, 32'h13);
        rd(REG_STO_ACC, a);
        check("pair_acc", a, 32'hABCDE);
        boot(8'h4C);
        check("ovr_chan", oper_chan, 5'h13);
        check("ovr_acc", oper_acc, 20'hABCDE);
        boot(8'h48);
        check("dip_chan", oper_chan, 5'h09);
        check("disp_chan", d_chan, 5'h13);
        enter_cfg();
        @(posedge clk);
        off_pin <= 1'b1;
        waitv(adapter_ready, 1'b0);
        check("cancel", adapter_ready, 1'b0);
        check("no_pair", infrared_receiver_pairing, 1'b0);
        conclude();
    end
endmodule : test_channel_source_ir_config_ctrl
